// ===== hdl/stlc_regs.svh
`ifndef STLC_REGS_SVH
`define STLC_REGS_SVH

// Command codes
`define STLC_CMD_SCAN 8'h4f
`define STLC_CMD_STD_SCAN 8'h36
`define STLC_CMD_VBP 8'h53
`define STLC_CMD_VFP 8'h54
`define STLC_CMD_HBP 8'h55
`define STLC_CMD_HFP 8'h56
`define STLC_CMD_BIAS 8'h57
`define STLC_CMD_LVD 8'h59
`define STLC_CMD_KEY 8'hff
`define STLC_KEY_VALUE 8'ha5

// Scan-direction fields
`define STLC_SCAN_ROW_BIT 7
`define STLC_SCAN_COL_BIT 6
`define STLC_SCAN_XCHG_BIT 5
`define STLC_SCAN_VREF_BIT 4
`define STLC_SCAN_BGR_BIT 3
`define STLC_SCAN_HREF_BIT 2
`define STLC_SCAN_RST 8'h00

// Porch defaults
`define STLC_VBP_RST 8'h00
`define STLC_VFP_RST 7'h00
`define STLC_HBP_RST 8'h00
`define STLC_HFP_RST 8'h00

// Bias fields
`define STLC_BIAS_SD_LSB 4
`define STLC_BIAS_GMA_LSB 2
`define STLC_BIAS_OTH_LSB 0
`define STLC_BIAS_RST 8'h2a
`define STLC_BIAS_NA_0 11'h1f4
`define STLC_BIAS_NA_1 11'h2ee
`define STLC_BIAS_NA_2 11'h3e8
`define STLC_BIAS_NA_3 11'h4e2

// Low-voltage-detect fields
`define STLC_LVD_BYP_BIT 6
`define STLC_LVD_GND_BIT 5
`define STLC_LVD_EN_BIT 4
`define STLC_LVD_FIXED_BIT 2
`define STLC_LVD_SEL_LSB 0
`define STLC_LVD_RST 8'h15
`define STLC_LVD_MV_0 12'h898
`define STLC_LVD_MV_1 12'h8fc
`define STLC_LVD_MV_2 12'h960
`define STLC_LVD_MV_3 12'h9c4

`endif

// ===== hdl/stlc_pkg.sv
package stlc_pkg;
    typedef logic [7:0] stlc_byte_t;
    typedef logic [1:0] stlc_sel_t;
    typedef enum logic [0:0] {
        STLC_KEY_LOCKED = 1'b0,
        STLC_KEY_OPEN = 1'b1
    } stlc_key_e;
endpackage : stlc_pkg

// ===== hdl/stlc_cmd_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "stlc_regs.svh"

module stlc_cmd_gate (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Command stream
    input wire logic i_cmd_valid,
    input wire stlc_pkg::stlc_byte_t i_cmd_code,
    input wire logic i_param_valid,
    input wire stlc_pkg::stlc_byte_t i_param_data,
    // Register write port
    output logic o_wr_stb,
    output stlc_pkg::stlc_byte_t o_wr_addr,
    output stlc_pkg::stlc_byte_t o_wr_data,
    output logic o_key_open
);
    import stlc_pkg::*;

    stlc_byte_t cmd_r;
    logic first_r;
    stlc_key_e key_r;
    logic take;

    // Only the first parameter after a command counts
    assign take = i_param_valid && first_r && !i_cmd_valid;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            cmd_r <= 8'h00;
            first_r <= 1'b0;
        end else if (i_cmd_valid) begin
            cmd_r <= i_cmd_code;
            first_r <= 1'b1;
        end else if (i_param_valid) begin
            first_r <= 1'b0;
        end
    end

    // R9: key written first
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            key_r <= STLC_KEY_LOCKED;
        end else if (take && cmd_r == `STLC_CMD_KEY) begin
            case (i_param_data == `STLC_KEY_VALUE)
                1'b1: key_r <= STLC_KEY_OPEN;
                default: key_r <= STLC_KEY_LOCKED;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_wr_stb <= 1'b0;
            o_wr_addr <= 8'h00;
            o_wr_data <= 8'h00;
        end else begin
            o_wr_stb <= take && cmd_r != `STLC_CMD_KEY;
            if (take) begin
                o_wr_addr <= cmd_r;
                o_wr_data <= i_param_data;
            end
        end
    end

    assign o_key_open = (key_r == STLC_KEY_OPEN);
endmodule : stlc_cmd_gate
`default_nettype wire

// ===== hdl/stlc_config_bank.sv
// Summary of operation
// R1: D7 reverses frame-memory row order
// R2: D6 reverses frame-memory column order
// R3: D5 swaps rows and columns
// R4: D4 refreshes panel bottom to top
// R5: D3 selects BGR subpixel order
// R6: D2 refreshes panel right to left
// R7: Scan register at 4Fh, resets zero
// R8: Command 36h writes same scan register
// R9: Host unlocks with A5 to FF first
// R10: 53h loads 8-bit vertical back porch
// R11: 54h loads 7-bit vertical front porch
// R12: 55h loads 8-bit horizontal back porch
// R13: 56h loads 8-bit horizontal front porch
// R14: 57h three bias fields, reset 2Ah
// R15: Bypass bit disables recovery precharge
// R16: Target bit picks ground or negative rail
// R17: 59h detector enable, reset 15h
// R18: Threshold codes select 2.2 to 2.5 V
// R19: Bank writes ignored while key closed; 36h still loads the scan bits while closed
// R20: Host keeps fixed D2 bit one
`timescale 1ns/1ps
`default_nettype none
`include "stlc_regs.svh"

module stlc_config_bank (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Command stream
    input wire logic i_cmd_valid,
    input wire stlc_pkg::stlc_byte_t i_cmd_code,
    input wire logic i_param_valid,
    input wire stlc_pkg::stlc_byte_t i_param_data,
    // Access status
    output logic o_key_open,
    output logic o_write_applied,
    output logic o_write_ignored,
    // Frame memory scan
    output logic o_row_order_reverse,
    output logic o_col_order_reverse,
    output logic o_row_col_exchange,
    output logic o_refresh_vertical_reverse,
    output logic o_bgr_order,
    output logic o_refresh_horizontal_reverse,
    // Timing generator porches
    output stlc_pkg::stlc_byte_t o_vertical_back_porch,
    output logic [6:0] o_vertical_front_porch,
    output stlc_pkg::stlc_byte_t o_horizontal_back_porch,
    output stlc_pkg::stlc_byte_t o_horizontal_front_porch,
    // Analog bias
    output stlc_pkg::stlc_sel_t o_source_bias_select,
    output stlc_pkg::stlc_sel_t o_gamma_bias_select,
    output stlc_pkg::stlc_sel_t o_other_bias_select,
    output logic [10:0] o_source_bias_na,
    output logic [10:0] o_gamma_bias_na,
    output logic [10:0] o_other_bias_na,
    // Low-voltage detect
    output logic o_lvd_recovery_bypass,
    output logic o_gate_precharge_enable,
    output logic o_precharge_to_ground,
    output logic o_precharge_to_negative_gate_rail,
    output logic o_lvd_enable,
    output stlc_pkg::stlc_sel_t o_lvd_threshold_select,
    output logic [11:0] o_lvd_threshold_mv
);
    import stlc_pkg::*;

    logic wr_stb;
    stlc_byte_t wr_addr;
    stlc_byte_t wr_data;
    logic key_open;

    stlc_cmd_gate u_gate (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_cmd_valid(i_cmd_valid),
        .i_cmd_code(i_cmd_code),
        .i_param_valid(i_param_valid),
        .i_param_data(i_param_data),
        .o_wr_stb(wr_stb),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_key_open(key_open)
    );

    function automatic logic in_bank(input stlc_byte_t a);
        case (a)
            `STLC_CMD_SCAN, `STLC_CMD_VBP, `STLC_CMD_VFP, `STLC_CMD_HBP,
            `STLC_CMD_HFP, `STLC_CMD_BIAS, `STLC_CMD_LVD: in_bank = 1'b1;
            default: in_bank = 1'b0;
        endcase
    endfunction : in_bank

    function automatic logic [10:0] bias_na(input stlc_sel_t c);
        case (c)
            2'h0: bias_na = `STLC_BIAS_NA_0;
            2'h1: bias_na = `STLC_BIAS_NA_1;
            2'h2: bias_na = `STLC_BIAS_NA_2;
            default: bias_na = `STLC_BIAS_NA_3;
        endcase
    endfunction : bias_na

    function automatic logic [11:0] lvd_mv(input stlc_sel_t c);
        case (c)
            2'h0: lvd_mv = `STLC_LVD_MV_0;
            2'h1: lvd_mv = `STLC_LVD_MV_1;
            2'h2: lvd_mv = `STLC_LVD_MV_2;
            default: lvd_mv = `STLC_LVD_MV_3;
        endcase
    endfunction : lvd_mv

    logic bank_wr;
    logic std_wr;
    logic scan_wr;

    // R19: key gates bank writes
    assign bank_wr = wr_stb && in_bank(wr_addr) && key_open;
    // R8: standard command always reaches scan bits
    assign std_wr = wr_stb && wr_addr == `STLC_CMD_STD_SCAN;
    assign scan_wr = std_wr || (bank_wr && wr_addr == `STLC_CMD_SCAN);

    // Scan-direction register, bits 7..2
    logic [7:2] scan_r;
    localparam stlc_byte_t SCAN_RST = `STLC_SCAN_RST;

    // R7: scan register load
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            scan_r <= SCAN_RST[7:2];
        end else if (scan_wr) begin
            scan_r <= wr_data[7:2];
        end
    end

    // R1: row order
    assign o_row_order_reverse = scan_r[`STLC_SCAN_ROW_BIT];
    // R2: column order
    assign o_col_order_reverse = scan_r[`STLC_SCAN_COL_BIT];
    // R3: row/column exchange
    assign o_row_col_exchange = scan_r[`STLC_SCAN_XCHG_BIT];
    // R4: vertical refresh order
    assign o_refresh_vertical_reverse = scan_r[`STLC_SCAN_VREF_BIT];
    // R5: subpixel order
    assign o_bgr_order = scan_r[`STLC_SCAN_BGR_BIT];
    // R6: horizontal refresh order
    assign o_refresh_horizontal_reverse = scan_r[`STLC_SCAN_HREF_BIT];

    // Porch registers
    stlc_byte_t vbp_r;
    logic [6:0] vfp_r;
    stlc_byte_t hbp_r;
    stlc_byte_t hfp_r;

    // R10: vertical back porch
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            vbp_r <= `STLC_VBP_RST;
        end else if (bank_wr && wr_addr == `STLC_CMD_VBP) begin
            vbp_r <= wr_data;
        end
    end

    // R11: vertical front porch, 7 bits
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            vfp_r <= `STLC_VFP_RST;
        end else if (bank_wr && wr_addr == `STLC_CMD_VFP) begin
            vfp_r <= wr_data[6:0];
        end
    end

    // R12: horizontal back porch
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            hbp_r <= `STLC_HBP_RST;
        end else if (bank_wr && wr_addr == `STLC_CMD_HBP) begin
            hbp_r <= wr_data;
        end
    end

    // R13: horizontal front porch
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            hfp_r <= `STLC_HFP_RST;
        end else if (bank_wr && wr_addr == `STLC_CMD_HFP) begin
            hfp_r <= wr_data;
        end
    end

    assign o_vertical_back_porch = vbp_r;
    assign o_vertical_front_porch = vfp_r;
    assign o_horizontal_back_porch = hbp_r;
    assign o_horizontal_front_porch = hfp_r;

    // Bias register, bits 5..0
    logic [5:0] bias_r;
    localparam stlc_byte_t BIAS_RST = `STLC_BIAS_RST;

    // R14: bias selections
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            bias_r <= BIAS_RST[5:0];
        end else if (bank_wr && wr_addr == `STLC_CMD_BIAS) begin
            bias_r <= wr_data[5:0];
        end
    end

    assign o_source_bias_select = bias_r[`STLC_BIAS_SD_LSB +: 2];
    assign o_gamma_bias_select = bias_r[`STLC_BIAS_GMA_LSB +: 2];
    assign o_other_bias_select = bias_r[`STLC_BIAS_OTH_LSB +: 2];

    // Bias currents in nA, one field per loop pass
    logic [10:0] bias_na_r [3];
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_bias
            always_ff @(posedge i_clock) begin
                if (i_reset) begin
                    bias_na_r[g] <= `STLC_BIAS_NA_2;
                end else begin
                    bias_na_r[g] <= bias_na(bias_r[2 * g +: 2]);
                end
            end
        end
    endgenerate

    assign o_other_bias_na = bias_na_r[0];
    assign o_gamma_bias_na = bias_na_r[1];
    assign o_source_bias_na = bias_na_r[2];

    // Low-voltage-detect register; fixed bit kept at one
    logic [6:0] lvd_r;
    localparam stlc_byte_t LVD_RST = `STLC_LVD_RST;

    // R17: detect register load
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            lvd_r <= LVD_RST[6:0];
        end else if (bank_wr && wr_addr == `STLC_CMD_LVD) begin
            lvd_r <= {wr_data[6:3], 1'b1, wr_data[1:0]};
        end
    end

    // R15: recovery precharge bypass
    assign o_lvd_recovery_bypass = lvd_r[`STLC_LVD_BYP_BIT];
    assign o_gate_precharge_enable = !lvd_r[`STLC_LVD_BYP_BIT];
    // R16: precharge target
    assign o_precharge_to_ground = lvd_r[`STLC_LVD_GND_BIT];
    assign o_precharge_to_negative_gate_rail = !lvd_r[`STLC_LVD_GND_BIT];
    assign o_lvd_enable = lvd_r[`STLC_LVD_EN_BIT];
    assign o_lvd_threshold_select = lvd_r[`STLC_LVD_SEL_LSB +: 2];

    // R18: threshold level
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_lvd_threshold_mv <= `STLC_LVD_MV_1;
        end else begin
            o_lvd_threshold_mv <= lvd_mv(lvd_r[1:0]);
        end
    end

    // Write outcome pulses
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_write_applied <= 1'b0;
            o_write_ignored <= 1'b0;
        end else begin
            o_write_applied <= bank_wr || std_wr;
            o_write_ignored <= wr_stb && in_bank(wr_addr) && !key_open;
        end
    end

    assign o_key_open = key_open;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    sequence s_scan_cmd;
        i_cmd_valid && !i_param_valid && i_cmd_code == `STLC_CMD_SCAN;
    endsequence

    sequence s_scan_param;
        i_param_valid && !i_cmd_valid && o_key_open;
    endsequence

    sequence s_locked_write;
        wr_stb && in_bank(wr_addr) && !o_key_open;
    endsequence

    a_scan_end_to_end: assert property ( // R1
        (o_key_open and s_scan_cmd) ##1 s_scan_param |->
            ##2 (o_row_order_reverse == $past(i_param_data[7], 2)
                && o_refresh_horizontal_reverse == $past(i_param_data[2], 2)))
        else $error("scan bits not loaded two cycles after parameter");

    a_scan_load: assert property ( // R7
        scan_wr |=> {o_row_order_reverse, o_col_order_reverse, o_row_col_exchange,
            o_refresh_vertical_reverse, o_bgr_order, o_refresh_horizontal_reverse}
            == $past(wr_data[7:2]))
        else $error("scan register did not take written bits");

    a_std_cmd_scan: assert property ( // R8
        (wr_stb && wr_addr == `STLC_CMD_STD_SCAN) |=> o_bgr_order == $past(wr_data[3]))
        else $error("standard scan command did not update colour order");

    a_locked_hold: assert property ( // R19
        s_locked_write |=> $stable(scan_r) && $stable(vbp_r) && $stable(vfp_r)
            && $stable(hbp_r) && $stable(hfp_r) && $stable(bias_r) && $stable(lvd_r)
            && o_write_ignored)
        else $error("locked write changed the bank");

    a_vfp_width: assert property ( // R11
        (bank_wr && wr_addr == `STLC_CMD_VFP) |=> o_vertical_front_porch == $past(wr_data[6:0]))
        else $error("front porch not loaded with seven bits");

    a_porch_load: assert property ( // R10
        (bank_wr && wr_addr == `STLC_CMD_VBP) |=> o_vertical_back_porch == $past(wr_data)
            ##1 $stable(o_vertical_back_porch) || bank_wr)
        else $error("vertical back porch not loaded");

    a_hporch_load: assert property ( // R12
        (bank_wr && wr_addr == `STLC_CMD_HBP) |=> o_horizontal_back_porch == $past(wr_data)
            && $stable(o_horizontal_front_porch))
        else $error("horizontal back porch load wrong");

    a_hfp_load: assert property ( // R13
        (bank_wr && wr_addr == `STLC_CMD_HFP) |=> o_horizontal_front_porch == $past(wr_data))
        else $error("horizontal front porch not loaded");

    a_bias_reset: assert property ( // R14
        $fell(i_reset) |-> bias_r == 6'h2a && o_source_bias_na == `STLC_BIAS_NA_2)
        else $error("bias register not at reset value");

    a_bias_current: assert property ( // R14
        ##1 o_source_bias_na == bias_na($past(o_source_bias_select)))
        else $error("source bias current does not follow code");

    a_lvd_reset: assert property ( // R17
        $fell(i_reset) |-> o_lvd_enable && o_lvd_threshold_select == 2'h1
            && !o_lvd_recovery_bypass && lvd_r[`STLC_LVD_FIXED_BIT])
        else $error("detect register not at reset value");

    a_precharge_bypass: assert property ( // R15
        (bank_wr && wr_addr == `STLC_CMD_LVD) |=>
            o_gate_precharge_enable == !$past(wr_data[6])
            && o_precharge_to_ground == $past(wr_data[5]))
        else $error("precharge controls not loaded");

    a_lvd_threshold: assert property ( // R18
        ##1 o_lvd_threshold_mv == lvd_mv($past(o_lvd_threshold_select)))
        else $error("threshold level does not follow code");
endmodule : stlc_config_bank
`default_nettype wire

// ===== testbench/stlc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "stlc_regs.svh"

module stlc_host_model (
    // Clock
    input wire logic i_clock,
    // Command stream
    output logic o_cmd_valid,
    output stlc_pkg::stlc_byte_t o_cmd_code,
    output logic o_param_valid,
    output stlc_pkg::stlc_byte_t o_param_data
);
    import stlc_pkg::*;

    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_code = 8'h00;
        o_param_valid = 1'b0;
        o_param_data = 8'h00;
    end

    // Idle bytes show the inverse of the last value
    task automatic send(input stlc_byte_t code, input stlc_byte_t data, input logic extra);
        stlc_byte_t d;
        d = (code == `STLC_CMD_LVD) ? (data | 8'h04) : data;
        @(posedge i_clock);
        o_cmd_valid <= 1'b1;
        o_cmd_code <= code;
        @(posedge i_clock);
        o_cmd_valid <= 1'b0;
        o_cmd_code <= ~code;
        o_param_valid <= 1'b1;
        o_param_data <= d;
        if (extra) begin
            @(posedge i_clock);
            o_param_data <= ~d;
        end
        @(posedge i_clock);
        o_param_valid <= 1'b0;
        o_param_data <= ~d;
    endtask : send

    task automatic unlock();
        send(`STLC_CMD_KEY, `STLC_KEY_VALUE, 1'b0);
    endtask : unlock
endmodule : stlc_host_model
`default_nettype wire

// ===== testbench/stlc_config_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "stlc_regs.svh"

module stlc_config_bank_tb_top;
    import stlc_pkg::*;
    typedef struct {stlc_byte_t cmd; stlc_byte_t data; logic [39:0] exp;} stlc_row_s;
    logic i_clock;
    logic i_reset;
    wire logic cv, pv;
    wire stlc_byte_t cc, pd;
    logic ko, wa, wi, rr, cr, xc, vr, bg, hr, lb, pe, pg, pn, le;
    stlc_byte_t vbp, hbp, hfp;
    logic [6:0] vfp;
    stlc_sel_t ss, gs, os, ls;
    logic [10:0] sn, gn, on;
    logic [11:0] mv;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    stlc_row_s rows [0:17];

    stlc_host_model i_stlc_host_model (.i_clock(i_clock), .o_cmd_valid(cv), .o_cmd_code(cc),
        .o_param_valid(pv), .o_param_data(pd));
    stlc_config_bank i_stlc_config_bank (.i_clock(i_clock), .i_reset(i_reset), .i_cmd_valid(cv),
        .i_cmd_code(cc), .i_param_valid(pv), .i_param_data(pd), .o_key_open(ko),
        .o_write_applied(wa), .o_write_ignored(wi), .o_row_order_reverse(rr), .o_col_order_reverse(cr),
        .o_row_col_exchange(xc), .o_refresh_vertical_reverse(vr), .o_bgr_order(bg),
        .o_refresh_horizontal_reverse(hr), .o_vertical_back_porch(vbp), .o_vertical_front_porch(vfp),
        .o_horizontal_back_porch(hbp), .o_horizontal_front_porch(hfp), .o_source_bias_select(ss),
        .o_gamma_bias_select(gs), .o_other_bias_select(os), .o_source_bias_na(sn), .o_gamma_bias_na(gn),
        .o_other_bias_na(on), .o_lvd_recovery_bypass(lb), .o_gate_precharge_enable(pe),
        .o_precharge_to_ground(pg), .o_precharge_to_negative_gate_rail(pn), .o_lvd_enable(le),
        .o_lvd_threshold_select(ls), .o_lvd_threshold_mv(mv));

    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    function automatic logic [39:0] view(input stlc_byte_t c);
        case (c)
            8'h4f, 8'h36: view = {34'h0, rr, cr, xc, vr, bg, hr};
            8'h53: view = {32'h0, vbp};
            8'h54: view = {33'h0, vfp};
            8'h55: view = {32'h0, hbp};
            8'h56: view = {32'h0, hfp};
            8'h57: view = {1'b0, ss, gs, os, sn, gn, on};
            default: view = {21'h0, lb, pe, pg, pn, le, ls, mv};
        endcase
    endfunction : view

    task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input stlc_byte_t c, input stlc_byte_t d, input logic extra, input logic [1:0] exp);
        logic [1:0] seen;
        seen = 2'b00;
        i_stlc_host_model.send(c, d, extra);
        #1;
        seen = seen | {wa === 1'b1, wi === 1'b1};
        repeat (5) begin
            @(posedge i_clock);
            #1;
            seen = seen | {wa === 1'b1, wi === 1'b1};
        end
        check("pulse", {38'h0, exp}, {38'h0, seen});
    endtask : wr

    task automatic do_reset();
        @(posedge i_clock);
        i_reset <= 1'b1;
        repeat (8) @(posedge i_clock);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clock);
        #1;
        check("scan_rst", 40'h0, view(8'h4f));
        check("bias_rst", {6'h2a, 11'h3e8, 11'h3e8, 11'h3e8}, view(8'h57));
        check("lvd_rst", {5'b01011, 2'b01, 12'h8fc}, view(8'h59));
        check("key_rst", 40'h0, {39'h0, ko});
        check("vbp_rst", 40'h0, view(8'h53));
    endtask : do_reset

    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        rows = '{
            '{8'h4f, 8'h80, 40'h20}, '{8'h4f, 8'h40, 40'h10}, '{8'h4f, 8'h20, 40'h08},
            '{8'h4f, 8'h10, 40'h04}, '{8'h4f, 8'h08, 40'h02}, '{8'h4f, 8'h04, 40'h01},
            '{8'h36, 8'h84, 40'h21},
            '{8'h53, 8'hff, 40'hff}, '{8'h54, 8'hff, 40'h7f}, '{8'h55, 8'ha5, 40'ha5},
            '{8'h56, 8'h3c, 40'h3c},
            '{8'h57, 8'h00, {6'h00, 11'h1f4, 11'h1f4, 11'h1f4}},
            '{8'h57, 8'h1b, {6'h1b, 11'h2ee, 11'h3e8, 11'h4e2}},
            '{8'h57, 8'he4, {6'h24, 11'h3e8, 11'h2ee, 11'h1f4}},
            '{8'h59, 8'h00, {5'b01010, 2'b00, 12'h898}},
            '{8'h59, 8'h41, {5'b10010, 2'b01, 12'h8fc}},
            '{8'h59, 8'h22, {5'b01100, 2'b10, 12'h960}},
            '{8'h59, 8'h93, {5'b01011, 2'b11, 12'h9c4}}};
        i_reset = 1'b1;
        do_reset();
        wr(8'h53, 8'h77, 1'b0, 2'b01);
        check("vbp_locked", 40'h0, view(8'h53));
        i_stlc_host_model.unlock();
        repeat (3) @(posedge i_clock);
        check("key_open", 40'h1, {39'h0, ko});
        for (int k = 0; k < 18; k++) begin
            wr(rows[k].cmd, rows[k].data, 1'b0, 2'b10);
            check("row", rows[k].exp, view(rows[k].cmd));
        end
        wr(8'h55, 8'h11, 1'b1, 2'b10);
        check("hbp_first", 40'h11, view(8'h55));
        wr(8'h5a, 8'h00, 1'b0, 2'b00);
        wr(8'hff, 8'h00, 1'b0, 2'b00);
        check("key_closed", 40'h0, {39'h0, ko});
        wr(8'h4f, 8'hff, 1'b0, 2'b01);
        check("scan_locked", 40'h21, view(8'h4f));
        do_reset();
        finish_test();
    end
endmodule : stlc_config_bank_tb_top
`default_nettype wire
